// file: pkg/timer_pkg.sv
package timer_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00C8;
    localparam logic [7:0] ADDR_RELOAD_LOW    = 8'h00CA;
    localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'h00CB;
    localparam logic [7:0] ADDR_COUNT_LOW     = 8'h00CC;
    localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h00CD;
    // timer_control field positions
    localparam int BIT_HIGH_OVF  = 7;
    localparam int BIT_LOW_OVF   = 6;
    localparam int BIT_LOW_IRQEN = 5;
    localparam int BIT_CAPT_EN   = 4;
    localparam int BIT_SPLIT     = 3;
    localparam int BIT_RUN       = 2;
    localparam int BIT_UNUSED    = 1;
    localparam int BIT_EXT_SEL   = 0;
    localparam logic [7:0] CONTROL_WMASK = 8'h00FD;
    localparam logic [7:0] RESET_BYTE    = 8'h0000;
    localparam logic [7:0] BYTE_MAX      = 8'h00FF;
    // prescaler counts
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
endpackage

// file: pkg/tick_if.sv
interface tick_if;
    logic tick_sys12;
    logic tick_ext8;
    modport src (output tick_sys12, output tick_ext8);
    modport dst (input tick_sys12, input tick_ext8);
endinterface

// file: design/timer_prescaler.sv
module timer_prescaler
    import timer_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic ext_clk_i,
    tick_if.src       ticks
);
    logic [3:0] sys_cnt;
    logic [2:0] ext_cnt;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_prev;
    logic       sys_tick;
    logic       ext_tick;
    wire        ext_rise = ext_sync & ~ext_prev;
    wire        sys_wrap = (sys_cnt == SYS_DIV_LAST);
    wire        ext_wrap = ext_rise & (ext_cnt == EXT_DIV_LAST);

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sys_cnt  <= '0;
            ext_cnt  <= '0;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            sys_tick <= 1'b0;
            ext_tick <= 1'b0;
        end else begin
            ext_meta <= ext_clk_i;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            sys_cnt  <= sys_wrap ? 4'h0 : sys_cnt + 4'h1;
            if (ext_rise) begin
                ext_cnt <= ext_cnt + 3'h1;
            end
            sys_tick <= sys_wrap;
            ext_tick <= ext_wrap;
        end
    end

    assign ticks.tick_sys12 = sys_tick;
    assign ticks.tick_ext8  = ext_tick;
endmodule

// file: design/split_timer.sv
// Function
// - count is a low byte and a high byte forming one 16-bit value.
// - control bit 3 selects one 16-bit or two 8-bit auto-reload timers.
// - 16-bit wrap loads the 16-bit reload value and sets high overflow flag.
// - split mode: each byte reloads from its own reload register on overflow.
// - run bit gates whole timer in 16-bit mode, only high byte in split.
// - per-byte select: 1 system clock, else external select picks div12 or ext div8.
// - low select clocks whole 16-bit timer; high select only matters in split mode.
// - external divided-by-8 source is synchronised to the system clock.
// - low flag sets on every low byte wrap; high flag on high byte wrap.
// - with timer_irq_enable_i high: interrupt on high overflow, and on low overflow when its enable is set.
// - hardware never clears overflow flags; software clears them by writing control.
// - capture enabled and timer_irq_enable_i high: oscillator falling edge copies count to reload, raises interrupt.
// - control bit 1 reads zero and ignores writes.
module split_timer
    import timer_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic       high_byte_clock_select_i,
    input  wire logic       low_byte_clock_select_i,
    input  wire logic       timer_irq_enable_i,
    input  wire logic       ext_clk_i,
    input  wire logic       lfo_i,
    output logic [7:0]      sfr_rdata_o,
    output logic            irq_o
);
    tick_if ticks ();

    timer_prescaler u_presc (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ext_clk_i (ext_clk_i),
        .ticks     (ticks)
    );

    logic [7:0] timer_control;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic       lfo_meta;
    logic       lfo_sync;
    logic       lfo_prev;
    logic       capt_pend;

    wire high_flag   = timer_control[BIT_HIGH_OVF];
    wire low_flag    = timer_control[BIT_LOW_OVF];
    wire low_irqen   = timer_control[BIT_LOW_IRQEN];
    wire capt_en     = timer_control[BIT_CAPT_EN];
    wire split_mode  = timer_control[BIT_SPLIT];
    wire run_control = timer_control[BIT_RUN];
    wire ext_select  = timer_control[BIT_EXT_SEL];

    // per-byte clock choice: system clock, divide-by-12 tick or synchronised ext/8 tick
    wire [1:0] byte_sel = {high_byte_clock_select_i, low_byte_clock_select_i};
    // low byte free-runs in split mode; high byte always obeys the run bit
    wire [1:0] byte_run = {run_control, split_mode | run_control};
    wire [1:0] byte_src;
    wire [1:0] byte_step;
    for (genvar b = 0; b < 2; b++) begin : g_byte_clk
        assign byte_src[b]  = byte_sel[b] ? 1'b1 :
                              (ext_select ? ticks.tick_ext8 : ticks.tick_sys12);
        assign byte_step[b] = byte_src[b] & byte_run[b];
    end

    // the low select clocks the whole timer in 16-bit mode
    wire low_inc   = byte_step[0];
    wire low_wrap  = low_inc & (count_low == BYTE_MAX);
    // in 16-bit mode the high select is ignored and the high byte follows the low wrap
    wire high_inc  = split_mode ? byte_step[1] : low_wrap;
    wire high_wrap = high_inc & (count_high == BYTE_MAX);
    wire wrap16    = ~split_mode & high_wrap;

    // register select decode shared by the write strobes and the read mux
    wire sel_ctrl = (sfr_addr_i == ADDR_TIMER_CONTROL);
    wire sel_rll  = (sfr_addr_i == ADDR_RELOAD_LOW);
    wire sel_rlh  = (sfr_addr_i == ADDR_RELOAD_HIGH);
    wire sel_cl   = (sfr_addr_i == ADDR_COUNT_LOW);
    wire sel_ch   = (sfr_addr_i == ADDR_COUNT_HIGH);

    wire wr_ctrl = sfr_wr_i & sel_ctrl;
    wire wr_rll  = sfr_wr_i & sel_rll;
    wire wr_rlh  = sfr_wr_i & sel_rlh;
    wire wr_cl   = sfr_wr_i & sel_cl;
    wire wr_ch   = sfr_wr_i & sel_ch;

    wire lfo_fall = lfo_prev & ~lfo_sync;
    wire capture  = lfo_fall & capt_en & timer_irq_enable_i;

    // next count values; low reload follows its own wrap in split mode, the pair in 16-bit
    wire [7:0] low_next =
        wr_cl ? sfr_wdata_i :
        (split_mode & low_wrap) ? reload_low :
        wrap16 ? reload_low :
        low_inc ? 8'(count_low + 8'h01) : count_low;
    wire [7:0] high_next =
        wr_ch ? sfr_wdata_i :
        high_wrap ? reload_high :
        high_inc ? 8'(count_high + 8'h01) : count_high;

    // flags: a hardware set wins over a software clear in the same cycle
    wire high_flag_set  = high_wrap;
    wire low_flag_set   = low_wrap;
    wire high_flag_sw   = wr_ctrl ? sfr_wdata_i[BIT_HIGH_OVF] : high_flag;
    wire low_flag_sw    = wr_ctrl ? sfr_wdata_i[BIT_LOW_OVF] : low_flag;
    wire high_flag_next = high_flag_set | high_flag_sw;
    wire low_flag_next  = low_flag_set | low_flag_sw;
    wire [7:0] ctrl_next = wr_ctrl ? (sfr_wdata_i & CONTROL_WMASK) : timer_control;
    wire [7:0] ctrl_full = {high_flag_next, low_flag_next, ctrl_next[5:0]};

    // unmapped addresses read as zero
    wire [7:0] rd_mux =
        sel_ctrl ? timer_control :
        sel_rll  ? reload_low :
        sel_rlh  ? reload_high :
        sel_cl   ? count_low :
        sel_ch   ? count_high : RESET_BYTE;

    // level request while a flag stands; capture gives a one-shot request
    wire high_req = high_flag;
    wire low_req  = low_irqen & low_flag;
    wire next_irq = timer_irq_enable_i & (high_req | low_req | capt_pend);

    // bit 1 is forced to zero on every store
    wire [7:0] ctrl_stored = {ctrl_full[7:2], 1'b0, ctrl_full[0]};

    // low-frequency oscillator: two synchroniser stages, then one cycle of history
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            lfo_meta <= 1'b0;
            lfo_sync <= 1'b0;
            lfo_prev <= 1'b0;
        end else begin
            lfo_meta <= lfo_i;
            lfo_sync <= lfo_meta;
            lfo_prev <= lfo_sync;
        end
    end

    // flags and fields are stored together; flags keep their hardware set
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            timer_control <= RESET_BYTE;
        end else begin
            timer_control <= ctrl_stored;
        end
    end

    // a software write to a count byte wins over counting and reload
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            count_low <= RESET_BYTE;
        end else begin
            count_low <= low_next;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            count_high <= RESET_BYTE;
        end else begin
            count_high <= high_next;
        end
    end

    // a capture overrides a software write to the reload pair in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            reload_low <= RESET_BYTE;
        end else if (capture) begin
            reload_low <= count_low;
        end else if (wr_rll) begin
            reload_low <= sfr_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            reload_high <= RESET_BYTE;
        end else if (capture) begin
            reload_high <= count_high;
        end else if (wr_rlh) begin
            reload_high <= sfr_wdata_i;
        end
    end

    // capture request reaches irq_o two cycles later, through capt_pend and the irq_o register
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            capt_pend <= 1'b0;
        end else begin
            capt_pend <= capture;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sfr_rdata_o <= RESET_BYTE;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= rd_mux;
        end
    end
endmodule

// file: verification/split_timer_props.sv
module split_timer_props
    import timer_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic       timer_irq_enable_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    wire rd_ctl = sfr_rd_i && sfr_addr_i == ADDR_TIMER_CONTROL;
    wire rd_rll = sfr_rd_i && !timer_irq_enable_i && sfr_addr_i == ADDR_RELOAD_LOW;
    sequence ctl_wr_rd;
        (sfr_wr_i && sfr_addr_i == ADDR_TIMER_CONTROL) ##2 rd_ctl;
    endsequence
    sequence rll_wr_rd;
        (sfr_wr_i && sfr_addr_i == ADDR_RELOAD_LOW) ##2 rd_rll;
    endsequence
    unused_bit_a: assert property (rd_ctl |=> !sfr_rdata_o[BIT_UNUSED])
        else $error("control bit 1 read as one");
    ctl_rw_a: assert property (ctl_wr_rd |=>
        (sfr_rdata_o & 8'h3D) == ($past(sfr_wdata_i, 3) & 8'h3D))
        else $error("control readback wrong");
    reload_rw_a: assert property (rll_wr_rd |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
        else $error("reload readback wrong");
    reset_val_a: assert property (!$past(nrst_i) ##1 rd_rll |=> sfr_rdata_o == RESET_BYTE)
        else $error("reload not zero after reset");
    rdata_hold_a: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without a read");
    unmapped_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'hC9 |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    irq_gate_a: assert property (!timer_irq_enable_i [*3] |-> !irq_o)
        else $error("interrupt while disabled");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(timer_irq_enable_i))
        else $error("interrupt rose without enable");
endmodule

bind split_timer split_timer_props chk (.*);

// file: verification/testbench.sv
module testbench
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, nrst = 0, wr = 0, rd = 0, hsel = 0, lsel = 0, en = 0, ext = 0;
    logic       lfo = 1, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    int         miscompares = 0, n_compared = 0;
    split_timer dut (.clk_sys_i(clk), .nrst_i(nrst), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .high_byte_clock_select_i(hsel),
        .low_byte_clock_select_i(lsel), .timer_irq_enable_i(en), .ext_clk_i(ext),
        .lfo_i(lfo), .sfr_rdata_o(rdata), .irq_o(irq));
    initial forever #5 clk = ~clk;
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk) #1;
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        @(posedge clk) #1;
        wr = 0;
        rd = 0;
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp, string what);
        acc(0, a, 8'h00);
        chk(what, exp, rdata);
    endtask
    task automatic wait_irq(logic lvl);
        for (int i = 0; i < 500 && irq !== lvl; i++) @(posedge clk) #1;
        if (irq !== lvl) begin
            chk("irq wait", 8'(lvl), 8'(irq));
            conclude();
        end
    endtask
    task automatic t_regs();
        for (int a = ADDR_RELOAD_LOW; a <= ADDR_COUNT_HIGH; a++)
            rdc(8'(a), 8'h00, "reset value");
        acc(1, ADDR_TIMER_CONTROL, 8'hFF);
        rdc(ADDR_TIMER_CONTROL, 8'hFD, "control");
        acc(1, ADDR_TIMER_CONTROL, 8'h00);
        rdc(8'hC9, 8'h00, "unmapped");
        $display("regs done");
    endtask
    task automatic t_wide();
        lsel = 1;
        acc(1, ADDR_RELOAD_LOW, 8'h34);
        rdc(ADDR_RELOAD_LOW, 8'h34, "reload");
        acc(1, ADDR_RELOAD_HIGH, 8'h12);
        acc(1, ADDR_COUNT_HIGH, 8'hFF);
        acc(1, ADDR_COUNT_LOW, 8'hF0);
        en = 1;
        acc(1, ADDR_TIMER_CONTROL, 8'h04);
        wait_irq(1);
        rdc(ADDR_TIMER_CONTROL, 8'hC4, "wrap flags");
        acc(1, ADDR_TIMER_CONTROL, 8'h00);
        wait_irq(0);
        rdc(ADDR_COUNT_HIGH, 8'h12, "reloaded high");
        $display("wide done");
    endtask
    task automatic t_split();
        acc(1, ADDR_RELOAD_LOW, 8'hF0);
        acc(1, ADDR_COUNT_LOW, 8'hFE);
        acc(1, ADDR_COUNT_HIGH, 8'h00);
        acc(1, ADDR_TIMER_CONTROL, 8'h28);
        wait_irq(1);
        rdc(ADDR_TIMER_CONTROL, 8'h68, "low flag");
        rdc(ADDR_COUNT_HIGH, 8'h00, "high gated");
        acc(1, ADDR_TIMER_CONTROL, 8'h00);
        wait_irq(0);
        acc(1, ADDR_COUNT_HIGH, 8'hFE);
        acc(1, ADDR_TIMER_CONTROL, 8'h0C);
        wait_irq(1);
        acc(1, ADDR_TIMER_CONTROL, 8'h00);
        wait_irq(0);
        rdc(ADDR_COUNT_HIGH, 8'h12, "split high reload");
        acc(1, ADDR_COUNT_HIGH, 8'h00);
        $display("split done");
    endtask
    task automatic t_div();
        lsel = 0;
        hsel = 1;
        acc(1, ADDR_COUNT_LOW, 8'h00);
        acc(1, ADDR_TIMER_CONTROL, 8'h04);
        repeat (120) @(posedge clk) #1;
        acc(1, ADDR_TIMER_CONTROL, 8'h00);
        acc(0, ADDR_COUNT_LOW, 8'h00);
        chk("div12", 8'h01, 8'(rdata >= 8'h09 && rdata <= 8'h0B));
        acc(1, ADDR_COUNT_LOW, 8'h00);
        acc(1, ADDR_TIMER_CONTROL, 8'h05);
        repeat (32) #20 ext = ~ext;
        repeat (8) @(posedge clk) #1;
        acc(1, ADDR_TIMER_CONTROL, 8'h00);
        rdc(ADDR_COUNT_LOW, 8'h02, "ext div8");
        $display("divider done");
    endtask
    task automatic t_cap();
        lsel = 1;
        acc(1, ADDR_COUNT_LOW, 8'h00);
        acc(1, ADDR_TIMER_CONTROL, 8'h14);
        repeat (20) @(posedge clk) #1;
        lfo = 0;
        wait_irq(1);
        acc(1, ADDR_TIMER_CONTROL, 8'h00);
        rdc(ADDR_RELOAD_HIGH, 8'h00, "captured high");
        acc(0, ADDR_RELOAD_LOW, 8'h00);
        chk("captured low", 8'h01, 8'(rdata >= 8'h14 && rdata <= 8'h20));
        $display("capture done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        t_regs();
        t_wide();
        t_split();
        t_div();
        t_cap();
        conclude();
    end
endmodule
